// File: rtl/iopci_defs.vh
// Constants for the I/O port, comparator and interrupt block.
// Assumes inclusion by the port module of the block; definitions only.
`ifndef IOPCI_DEFS_VH
`define IOPCI_DEFS_VH

// Register indices on the plain register port
`define IOPCI_A_GRP_DATA   4'h0
`define IOPCI_A_BIT_DATA   4'h1
`define IOPCI_A_BIT_DIR    4'h2
`define IOPCI_A_CTRL       4'h3
`define IOPCI_A_IN_DATA    4'h4
`define IOPCI_A_IRQ_STAT   4'h5
`define IOPCI_A_IRQ_MASK   4'h6
`define IOPCI_A_PAD_STATE  4'h7

// Control register fields
`define IOPCI_C_GRP_OUT    0
`define IOPCI_C_OPEN_DRAIN 1
`define IOPCI_C_ANALOG     2

// Reset values
`define IOPCI_RST_CTRL     8'h00
`define IOPCI_RST_BIT_DIR  8'hFF
`define IOPCI_RST_BYTE     8'h00

// Interrupt request bit positions
`define IOPCI_IRQ_0        0
`define IOPCI_IRQ_1        1
`define IOPCI_IRQ_2        2
`define IOPCI_IRQ_3        3
`define IOPCI_IRQ_W        4

// Fill cycles of synchroniser and edge history after reset
`define IOPCI_WARM_CYCLES  2'h3

`endif

// File: rtl/iopci_edge.v
// Edge detector producing one-cycle pulses from synchronised levels.
// Assumes its input is already in the clk domain.
`timescale 1ns/1ps
`default_nettype none
module iopci_edge #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] fall
);

  reg [WIDTH-1:0] prev_r;

  // Previous sample of each level
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      prev_r <= {WIDTH{1'b0}};
    end else begin
      prev_r <= level;
    end
  end

  assign rise = level & ~prev_r;
  assign fall = ~level & prev_r;

endmodule // iopci_edge
`default_nettype wire

// File: rtl/iopci_ports.v
// I/O port logic: grouped port, bitwise port, input-only port,
// comparators and edge interrupt requests, with a register port.
// Assumes pad wires are resolved outside; comparators are analog macros
// whose outputs and power control are ports of this block.
// Limits: stop-mode entry, power-on sequencing and pad electrical
// behaviour are outside this block; the keeper is modelled only
// as the value read back, not as a drive onto the pad.
`timescale 1ns/1ps
`default_nettype none
`include "iopci_defs.vh"
module iopci_ports #(
  parameter GRP_W = 3,
  parameter BIT_W = 8,
  parameter IN_W  = 3
) (
  input  wire             clk,
  input  wire             reset,
  input  wire [3:0]       regAddr,
  input  wire [7:0]       regWrData,
  input  wire             regWrite,
  input  wire             regRead,
  output reg  [7:0]       regRdData,
  input  wire [GRP_W-1:0] groupDirPortIn,
  output wire [GRP_W-1:0] groupDirPortOut,
  output wire [GRP_W-1:0] groupDirPortOe,
  input  wire [BIT_W-1:0] bitwiseDirPortIn,
  output wire [BIT_W-1:0] bitwiseDirPortOut,
  output wire [BIT_W-1:0] bitwiseDirPortOe,
  input  wire [IN_W-1:0]  inputOnlyPortIn,
  input  wire             cmp1Out,
  input  wire             cmp2Out,
  output wire             cmpPowerOn,
  output wire             analogSelect,
  input  wire             stopMode,
  output wire [`IOPCI_IRQ_W-1:0] externalIrqRequests,
  output wire             timerInput,
  output wire             irq
);

  ////////////////////////////////////////////////////////////////////////
  // Software registers
  // Register map, one byte per index:
  //   0  group data; reads return the synchronised pad levels
  //   1  bitwise data; reads return the synchronised pad levels
  //   2  bitwise direction, a one makes the line an input
  //   3  control: group output, open drain, analog enable
  //   4  input-only levels after the analog selection
  //   5  request flags, write a one to clear a flag
  //   6  request mask for the interrupt output
  //   7  comparator power and synchronised comparator outputs
  // Other indices read as zero and ignore writes.
  // Data registers reset to zero and every bitwise line to input,
  // so nothing is driven until software has set a direction.

  reg [GRP_W-1:0]        grpData_r;
  reg [BIT_W-1:0]        bitData_r;
  reg [BIT_W-1:0]        bitDir_r;
  reg [7:0]              ctrl_r;
  reg [`IOPCI_IRQ_W-1:0] irqStat_r;
  reg [`IOPCI_IRQ_W-1:0] irqMask_r;
  reg [GRP_W-1:0]        grpKeep_r;
  reg [BIT_W-1:0]        bitKeep_r;
  reg [`IOPCI_IRQ_W-1:0] irqStat_nxt;

  wire grpOut    = ctrl_r[`IOPCI_C_GRP_OUT];
  wire openDrain = ctrl_r[`IOPCI_C_OPEN_DRAIN];
  wire analogEn  = ctrl_r[`IOPCI_C_ANALOG];

  // Address match helper used by every register write
  function wrHit;
    input       wr;
    input [3:0] addr;
    input [3:0] idx;
    begin
      wrHit = wr & (addr == idx);
    end
  endfunction

  // Writes take effect at the edge that samples the strobe; the
  // slave never stalls, so back-to-back writes are fine.
  // Register writes
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      grpData_r <= {GRP_W{1'b0}};
      bitData_r <= {BIT_W{1'b0}};
      bitDir_r  <= {BIT_W{1'b1}};
      ctrl_r    <= `IOPCI_RST_CTRL;
      irqMask_r <= {`IOPCI_IRQ_W{1'b0}};
    end else begin
      if (wrHit(regWrite, regAddr, `IOPCI_A_GRP_DATA))
        grpData_r <= regWrData[GRP_W-1:0];
      if (wrHit(regWrite, regAddr, `IOPCI_A_BIT_DATA))
        bitData_r <= regWrData[BIT_W-1:0];
      if (wrHit(regWrite, regAddr, `IOPCI_A_BIT_DIR))
        bitDir_r <= regWrData[BIT_W-1:0];
      if (wrHit(regWrite, regAddr, `IOPCI_A_CTRL))
        ctrl_r <= regWrData;
      if (wrHit(regWrite, regAddr, `IOPCI_A_IRQ_MASK))
        irqMask_r <= regWrData[`IOPCI_IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output drivers
  // Data registers feed the pads directly; the enables decide who
  // drives. Software should load data before turning a line to
  // output, else the old data value appears on the pin first.

  assign groupDirPortOut = grpData_r;
  assign groupDirPortOe  = {GRP_W{grpOut}};

  assign bitwiseDirPortOut = bitData_r;
  assign bitwiseDirPortOe  = ~bitDir_r & (openDrain ? ~bitData_r
                                                    : {BIT_W{1'b1}});
  // In open-drain mode a one releases the line; the level read back
  // is then whatever the external pull or driver makes of it.

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  // Pads and comparator outputs change with no regard to clk. Two
  // flops in a row give a metastable first stage a full cycle to
  // settle; nothing but the second stage reads the first.

  wire [GRP_W-1:0] grpSync;
  wire [BIT_W-1:0] bitSync;
  wire [IN_W-1:0]  inSync;
  wire [1:0]       cmpSync;

  iopci_sync #(.WIDTH(GRP_W + BIT_W + IN_W + 2)) uSync (
    .clk     (clk),
    .reset   (reset),
    .asyncIn ({groupDirPortIn, bitwiseDirPortIn, inputOnlyPortIn,
               cmp2Out, cmp1Out}),
    .syncOut ({grpSync, bitSync, inSync, cmpSync})
  );

  // The keeper copies the last synchronised level of every pad of
  // the two bidirectional ports; a line left undriven reads back
  // the level last seen on it. Input-only lines have no keeper.
  // Keepers follow any driven level
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      grpKeep_r <= {GRP_W{1'b0}};
      bitKeep_r <= {BIT_W{1'b0}};
    end else begin
      grpKeep_r <= grpSync;
      bitKeep_r <= bitSync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Comparators and input-only port
  // The analog select switches the three input-only pads to the
  // comparators: line 0 and line 1 are the non-inverting inputs
  // and line 2 the common reference. Power is removed whenever
  // the core stops; the block reads their outputs again from the
  // first cycle that power returns, with no settling hold-off.

  assign cmpPowerOn   = analogEn & ~stopMode;
  assign analogSelect = analogEn;

  // Reference on top line; outputs replace data
  // Reference line digital when comparators are off
  wire [IN_W-1:0] inLevel = analogEn ? {inSync[2], cmpSync[1], cmpSync[0]}
                                     : inSync;

  // The timer sees the same synchronised level as the port data
  // Timer input from bit 0 of the selected level, comparator 1 in analog
  assign timerInput = inLevel[0];

  wire [IN_W-1:0] inRise;
  wire [IN_W-1:0] inFall;

  // Edge history of the selected levels, one cycle per edge
  iopci_edge #(.WIDTH(IN_W)) uEdge (
    .clk   (clk),
    .reset (reset),
    .level (inLevel),
    .rise  (inRise),
    .fall  (inFall)
  );

  ////////////////////////////////////////////////////////////////////////
  // Edge qualification after reset

  // Synchronisers and edge history reset to zero, so a pad that is
  // high at reset would look like a rising edge once the pipeline
  // fills. Edges are ignored until both synchroniser stages and the
  // edge history hold real pad levels.
  reg  [1:0] warmCnt_r;
  wire       edgesLive = (warmCnt_r == `IOPCI_WARM_CYCLES);

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      warmCnt_r <= 2'h0;
    end else if (!edgesLive) begin
      warmCnt_r <= warmCnt_r + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt request flags

  // Request flag layout:
  //   digital: 0 line 0 falls, 1 line 2 falls,
  //            2 line 1 falls, 3 line 1 rises
  //   analog:  0 comparator 1 falls, 2 comparator 2 either edge,
  //            3 comparator 2 rises, 1 never set
  // The source of every flag changes with the analog select, so a
  // level step at the switch may look like an edge; software clears
  // all four flags after switching.

  reg [`IOPCI_IRQ_W-1:0] irqEvent;

  // Comparator 2 both edges, comparator 1 falling
  always @* begin
    irqEvent = {`IOPCI_IRQ_W{1'b0}};
    irqEvent[`IOPCI_IRQ_0] = inFall[0];
    irqEvent[`IOPCI_IRQ_2] = inFall[1];
    irqEvent[`IOPCI_IRQ_3] = inRise[1];
    if (analogEn) begin
      irqEvent[`IOPCI_IRQ_2] = inFall[1] | inRise[1];
      irqEvent[`IOPCI_IRQ_1] = 1'b0;
    end else begin
      // Reference line as its own request
      irqEvent[`IOPCI_IRQ_1] = inFall[2];
    end
    if (!edgesLive) begin
      irqEvent = {`IOPCI_IRQ_W{1'b0}};
    end
  end

  // Event set wins over write-one clear
  always @* begin
    irqStat_nxt = irqStat_r;
    if (wrHit(regWrite, regAddr, `IOPCI_A_IRQ_STAT))
      irqStat_nxt = irqStat_r & ~regWrData[`IOPCI_IRQ_W-1:0];
    irqStat_nxt = irqStat_nxt | irqEvent;
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      irqStat_r <= {`IOPCI_IRQ_W{1'b0}};
    end else begin
      irqStat_r <= irqStat_nxt;
    end
  end

  assign externalIrqRequests = irqStat_r;
  assign irq = |(irqStat_r & irqMask_r);

  ////////////////////////////////////////////////////////////////////////
  // Register read port

  // Outside the answer cycle the read data are zero, so a master
  // that samples a cycle late sees zero rather than stale data.
  // Read data stand one cycle after the strobe
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      regRdData <= `IOPCI_RST_BYTE;
    end else if (regRead) begin
      case (regAddr)
        `IOPCI_A_GRP_DATA:  regRdData <= {5'h00, grpKeep_r};
        `IOPCI_A_BIT_DATA:  regRdData <= bitKeep_r;
        `IOPCI_A_BIT_DIR:   regRdData <= bitDir_r;
        `IOPCI_A_CTRL:      regRdData <= ctrl_r;
        `IOPCI_A_IN_DATA:   regRdData <= {5'h00, inLevel};
        `IOPCI_A_IRQ_STAT:  regRdData <= {4'h0, irqStat_r};
        `IOPCI_A_IRQ_MASK:  regRdData <= {4'h0, irqMask_r};
        `IOPCI_A_PAD_STATE: regRdData <= {5'h00, cmpPowerOn, cmpSync};
        default:            regRdData <= `IOPCI_RST_BYTE;
      endcase
    end else begin
      regRdData <= `IOPCI_RST_BYTE;
    end
  end

endmodule // iopci_ports
`default_nettype wire

// File: rtl/iopci_sync.v
// Two-stage synchroniser for a vector of asynchronous levels.
// Assumes the inputs are pins or analog comparator outputs.
`timescale 1ns/1ps
`default_nettype none
module iopci_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] meta_r;

  // First stage is read only by the second stage
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r  <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end else begin
      meta_r  <= asyncIn;
      syncOut <= meta_r;
    end
  end

endmodule // iopci_sync
`default_nettype wire

// File: sim/iopci_chk.sv
// Checker of pad, comparator and request behaviour.
// Bound into iopci_ports; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module iopci_chk #(
  parameter GRP_W = 3,
  parameter IN_W  = 3
) (
  input wire             clk,
  input wire             reset,
  input wire [3:0]       regAddr,
  input wire             regWrite,
  input wire             regRead,
  input wire [7:0]       regRdData,
  input wire [GRP_W-1:0] groupDirPortOe,
  input wire [IN_W-1:0]  inputOnlyPortIn,
  input wire             cmpPowerOn,
  input wire             analogSelect,
  input wire             stopMode,
  input wire [3:0]       externalIrqRequests,
  input wire             timerInput,
  input wire             irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////
  // Port relations
  a_grp_one_dir: assert property (
    &groupDirPortOe || !(|groupDirPortOe)) else $error("group dir split");
  a_stop_off: assert property (
    stopMode |-> !cmpPowerOn) else $error("power in stop");
  a_power_analog: assert property (
    cmpPowerOn |-> analogSelect) else $error("power in digital");
  a_read_idle: assert property (
    !$past(regRead) |-> regRdData == 8'h00) else $error("stale read");
  a_flag_sticky: assert property (
    |($past(externalIrqRequests) & ~externalIrqRequests) |->
    $past(regWrite) && $past(regAddr) == 4'h5) else $error("flag lost");
  a_irq_flag: assert property (
    irq |-> |externalIrqRequests) else $error("irq unflagged");
  a_line_fall: assert property (
    $rose(externalIrqRequests[0]) && !analogSelect && !$past(analogSelect, 4)
    |-> !$past(inputOnlyPortIn[0], 2) || !$past(inputOnlyPortIn[0], 3) ||
    !$past(inputOnlyPortIn[0], 4)) else $error("flag without fall");
  a_timer_line: assert property (
    !analogSelect && !$past(analogSelect, 2) && !$past(reset, 2) |->
    timerInput == $past(inputOnlyPortIn[0], 2)) else $error("timer input");
  a_ref_silent: assert property (
    analogSelect && $past(analogSelect) |-> !$rose(externalIrqRequests[1]))
    else $error("reference line flagged in analog");
  // Main scenarios
  c_irq: cover property ($rose(irq));
  c_power: cover property ($rose(cmpPowerOn));
  c_cmp: cover property (analogSelect && $rose(externalIrqRequests[2]));
endmodule // iopci_chk
bind iopci_ports iopci_chk #(.GRP_W(GRP_W), .IN_W(IN_W)) u_chk (.*);
`default_nettype wire

// File: sim/iopci_pads.sv
// Far-side model: pad wires and the two comparators.
// Assumes the bench sets external drive and analog levels.
`timescale 1ns/1ps
`default_nettype none
module iopci_pads (
  input  wire logic [2:0] groupDirPortOut,
  input  wire logic [2:0] groupDirPortOe,
  input  wire logic [7:0] bitwiseDirPortOut,
  input  wire logic [7:0] bitwiseDirPortOe,
  input  wire logic [2:0] grpDrive,
  input  wire logic [7:0] bitDrive,
  input  wire logic       cmpPowerOn,
  input  wire logic [1:0] cmpLevel,
  output wire logic [2:0] groupDirPortIn,
  output wire logic [7:0] bitwiseDirPortIn,
  output wire logic       cmp1Out,
  output wire logic       cmp2Out
);
  ////////////////////
  // pad level resolution
  assign groupDirPortIn = (groupDirPortOut & groupDirPortOe) |
    (grpDrive & ~groupDirPortOe);
  assign bitwiseDirPortIn = (bitwiseDirPortOut & bitwiseDirPortOe) |
    (bitDrive & ~bitwiseDirPortOe);
  assign cmp1Out = cmpPowerOn & cmpLevel[0];
  assign cmp2Out = cmpPowerOn & cmpLevel[1];
endmodule // iopci_pads
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench of the port block through its register port.
// Assumes design files and pad model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clk, reset, regWrite, regRead, stopMode, cmp1Out, cmp2Out;
  logic       cmpPowerOn, analogSelect, timerInput, irq;
  logic [3:0] regAddr, externalIrqRequests;
  logic [7:0] regWrData, regRdData, bitDrive, bitwiseDirPortIn;
  logic [7:0] bitwiseDirPortOut, bitwiseDirPortOe;
  logic [2:0] grpDrive, groupDirPortIn, groupDirPortOut, groupDirPortOe;
  logic [2:0] inputOnlyPortIn;
  logic [1:0] cmpLevel;
  int         fail_count = 0;
  int         num_checks = 0;
  int         cycles = 0;
  ////////////////////
  // Design and far side
  iopci_ports u_iopci_ports (.*);
  iopci_pads u_iopci_pads (.*);
  // Clock of 25 ns
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  // Read, data taken in the following cycle
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk($sformatf("reg %h", a), regRdData, e);
  endtask
  // Counts and verdict
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      end_of_test();
    end
  end
  // Test sequence
  initial begin
    {regWrite, regRead, stopMode, regAddr, regWrData} = '0;
    {grpDrive, bitDrive, inputOnlyPortIn, cmpLevel} = '0;
    reset = 1'b1;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(4'h2, 8'hFF);
    chk("oe", bitwiseDirPortOe | groupDirPortOe, 8'h00);
    $display("test reset done");
    @(posedge clk);
    bitDrive <= 8'hC3;
    wr(4'h3, 8'h01);
    wr(4'h0, 8'h05);
    wr(4'h2, 8'h0F);
    wr(4'h1, 8'hA5);
    repeat (3) @(posedge clk);
    chk("grpOe", groupDirPortOe, 8'h07);
    chk("bitOe", bitwiseDirPortOe, 8'hF0);
    chk("grpOut", groupDirPortOut, 8'h05);
    chk("bitOut", bitwiseDirPortOut, 8'hA5);
    rd(4'h0, 8'h05);
    rd(4'h1, 8'hA3);
    wr(4'h3, 8'h03);
    #1 chk("odOe", bitwiseDirPortOe, 8'h50);
    $display("test ports done");
    wr(4'h6, 8'h0F);
    inputOnlyPortIn <= 3'h7;
    repeat (6) @(posedge clk);
    rd(4'h4, 8'h07);
    chk("tin", timerInput, 8'h01);
    rd(4'h5, 8'h08);
    chk("irq", irq, 8'h01);
    wr(4'h5, 8'h0F);
    inputOnlyPortIn <= 3'h0;
    repeat (6) @(posedge clk);
    rd(4'h5, 8'h07);
    wr(4'h5, 8'h0F);
    #1 chk("irq", irq, 8'h00);
    $display("test digital done");
    // requests off, analog on, flags cleared
    wr(4'h6, 8'h00);
    wr(4'h3, 8'h04);
    wr(4'h5, 8'h0F);
    #1 chk("pwr", cmpPowerOn, 8'h01);
    repeat (2) @(posedge clk);
    cmpLevel <= 2'h3;
    repeat (6) @(posedge clk);
    rd(4'h5, 8'h0C);
    chk("tin", timerInput, 8'h01);
    chk("irq", irq, 8'h00);
    wr(4'h5, 8'h0F);
    cmpLevel <= 2'h0;
    repeat (6) @(posedge clk);
    rd(4'h5, 8'h05);
    chk("flags", externalIrqRequests, 8'h05);
    rd(4'h7, 8'h04);
    wr(4'h6, 8'h0F);
    #1 chk("irq", irq, 8'h01);
    chk("ana", analogSelect, 8'h01);
    @(posedge clk);
    stopMode <= 1'b1;
    @(posedge clk);
    #1 chk("pwr", cmpPowerOn, 8'h00);
    wr(4'h8, 8'hFF);
    rd(4'h8, 8'h00);
    rd(4'h3, 8'h04);
    $display("test analog done");
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
